/* rtl/pcrs_pkg.sv */
// Package for the program counter and return stack block
// Contract
// R1: Program counter is 21 bits in three bytes; only low byte software visible.
// R2: Middle byte loads only through the high holding latch.
// R3: Upper byte loads only through the upper holding latch.
// R4: Writing the low byte moves both latches into the counter upper bytes.
// R5: Reading the low byte copies counter upper bytes into both latches.
// R6: Counter bit zero is always zero.
// R7: Sequential advance adds two.
// R8: Call, relative call, goto and branch load the target, latches unused.
// R9: Stack holds 31 entries; call, relative call, interrupt acknowledge push.
// R10: Return, return with literal, return from interrupt pop into counter.
// R11: Calls and returns leave both holding latches unchanged.
// R12: Stack is a private 31 by 21 memory indexed by 5-bit pointer.
// R13: Software reads and writes stack pointer and top of stack entry.
// R14: Push increments pointer first, then writes the advanced counter there; interrupt acknowledge push writes the counter unadvanced.
// R15: Pop loads counter from pointed entry, then decrements pointer.
// R16: Every reset clears the pointer; zero is the empty state only.
// R17: Overflow and underflow reported in power control status register.
// R18: Top of stack byte registers mirror and update the pointed entry.
// R19: Software disables global interrupts while touching stack registers.
// R20: Push past deepest sets overflow, pop at empty sets underflow, no wrap.
`default_nettype none
package pcrs_pkg;

  localparam int PC_W    = 21;
  localparam int SP_W    = 5;
  localparam int DEPTH   = 31;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_PC_LOW     = 4'h0;
  localparam logic [3:0] OFS_PC_HLATCH  = 4'h1;
  localparam logic [3:0] OFS_PC_ULATCH  = 4'h2;
  localparam logic [3:0] OFS_TOP_LOW    = 4'h3;
  localparam logic [3:0] OFS_TOP_HIGH   = 4'h4;
  localparam logic [3:0] OFS_TOP_UPPER  = 4'h5;
  localparam logic [3:0] OFS_STACK_PTR  = 4'h6;
  localparam logic [3:0] OFS_PWR_STAT0  = 4'h7;

  // Status bit positions in power_control_status0
  localparam int STAT_OVF_BIT = 7;
  localparam int STAT_UNF_BIT = 6;

  localparam logic [PC_W-1:0] PC_RESET  = 21'h000000;
  localparam logic [SP_W-1:0] SP_RESET  = 5'h00;
  localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;

  // Core control requests, at most one per cycle honoured by priority
  typedef struct packed {
    logic              advance;
    logic              load_target;
    logic              push_call;
    logic              push_irq;
    logic              pop;
    logic [PC_W-1:0]   target;
  } pcrs_core_req_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } pcrs_reg_req_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADVANCE,
    OP_LOAD,
    OP_PUSH,
    OP_POP
  } pcrs_op_t;

endpackage : pcrs_pkg
`default_nettype wire

/* rtl/pcrs_stack_mem.sv */
// Return stack storage: 31 words of program counter width
`timescale 1ns/100ps
`default_nettype none
module pcrs_stack_mem #(
  parameter int DEPTH = pcrs_pkg::DEPTH,
  parameter int W     = pcrs_pkg::PC_W,
  parameter int AW    = pcrs_pkg::SP_W
) (
  // Clock
  input  wire logic          clock_i,
  input  wire logic          ce_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // Asynchronous read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  // Index zero has no storage; entries 1..DEPTH live in mem[0..DEPTH-1]
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clock_i)
  begin
    if (ce_i && we_i && waddr_i != '0 && 32'(waddr_i) <= DEPTH)
    begin
      mem[32'(waddr_i) - 1] <= wdata_i; // [R12]
    end
  end

  always_comb
  begin
    if (raddr_i == '0 || 32'(raddr_i) > DEPTH)
    begin
      rdata_o = '0;
    end
    else
    begin
      rdata_o = mem[32'(raddr_i) - 1];
    end
  end

endmodule // pcrs_stack_mem
`default_nettype wire

/* rtl/pcrs_top.sv */
// Program counter, holding latches and return address stack
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pcrs_top (
  // Clock, enable and reset
  input  wire logic                        clock_i,
  input  wire logic                        ce_i,
  input  wire logic                        rstn_i,
  // Core decode requests
  input  wire pcrs_pkg::pcrs_core_req_t    core_i,
  // Register port
  input  wire pcrs_pkg::pcrs_reg_req_t     reg_i,
  output logic [7:0]                       rdata_o,
  // Fetch address and stack flags
  output logic [pcrs_pkg::PC_W-1:0]        pc_o,
  output logic                             stack_overflow_o,
  output logic                             stack_underflow_o
);

  localparam int W  = pcrs_pkg::PC_W;
  localparam int AW = pcrs_pkg::SP_W;

  logic [W-1:0]   pc;
  logic [7:0]     pc_high_latch;
  logic [4:0]     pc_upper_latch;
  logic [AW-1:0]  stack_pointer_reg;
  logic           ovf;
  logic           unf;
  logic [W-1:0]   top_of_stack;
  logic           mem_we;
  logic [AW-1:0]  mem_waddr;
  logic [W-1:0]   mem_wdata;
  logic [W-1:0]   next_pc;
  logic [W-1:0]   next_pc_seq;
  pcrs_pkg::pcrs_op_t op;

  function automatic logic [W-1:0] align(input logic [W-1:0] v);
    return {v[W-1:1], 1'b0};
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  wire logic sw_wr   = reg_i.wr;
  wire logic sw_rd   = reg_i.rd;
  wire logic full    = (32'(stack_pointer_reg) >= pcrs_pkg::DEPTH);
  wire logic empty   = (stack_pointer_reg == '0);
  wire logic pushing = core_i.push_call || core_i.push_irq;

  // Core op priority: pop, push, load, advance
  always_comb
  begin
    if (core_i.pop)
    begin
      op = pcrs_pkg::OP_POP;
    end
    else if (pushing)
    begin
      op = pcrs_pkg::OP_PUSH;
    end
    else if (core_i.load_target)
    begin
      op = pcrs_pkg::OP_LOAD;
    end
    else if (core_i.advance)
    begin
      op = pcrs_pkg::OP_ADVANCE;
    end
    else
    begin
      op = pcrs_pkg::OP_NONE;
    end
  end

  assign next_pc_seq = W'(pc + pcrs_pkg::PC_STEP); // [R7]

  // Calls jump to the target; interrupt acknowledge jumps via target too
  always_comb
  begin
    next_pc = pc;
    case (op)
      pcrs_pkg::OP_ADVANCE: next_pc = next_pc_seq;
      pcrs_pkg::OP_LOAD:    next_pc = align(core_i.target); // [R8]
      pcrs_pkg::OP_PUSH:    next_pc = align(core_i.target); // [R8]
      pcrs_pkg::OP_POP:     next_pc = empty ? pc : align(top_of_stack); // [R10] [R15]
      pcrs_pkg::OP_NONE:    next_pc = pc;
      default:              next_pc = pc;
    endcase
  end

  // Program counter; a software low byte write takes the latches along
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      pc <= pcrs_pkg::PC_RESET;
    end
    else if (ce_i)
    begin
      if (op != pcrs_pkg::OP_NONE)
      begin
        pc <= next_pc;
      end
      else if (sw_wr && hit(reg_i.addr, pcrs_pkg::OFS_PC_LOW))
      begin
        pc <= {pc_upper_latch, pc_high_latch, reg_i.wdata[7:1], 1'b0}; // [R1] [R2] [R3] [R4] [R6]
      end
    end
  end

  // Holding latches: untouched by calls and returns
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      pc_high_latch  <= 8'h00;
      pc_upper_latch <= 5'h00;
    end
    else if (ce_i)
    begin
      if (sw_rd && hit(reg_i.addr, pcrs_pkg::OFS_PC_LOW))
      begin
        pc_high_latch  <= pc[15:8]; // [R5]
        pc_upper_latch <= pc[20:16]; // [R5]
      end
      else if (sw_wr && hit(reg_i.addr, pcrs_pkg::OFS_PC_HLATCH))
      begin
        pc_high_latch <= reg_i.wdata; // [R2] [R11]
      end
      else if (sw_wr && hit(reg_i.addr, pcrs_pkg::OFS_PC_ULATCH))
      begin
        pc_upper_latch <= reg_i.wdata[4:0]; // [R3] [R11]
      end
    end
  end

  // Stack pointer: no wrap on overflow or underflow
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      stack_pointer_reg <= pcrs_pkg::SP_RESET; // [R16]
    end
    else if (ce_i)
    begin
      if (op == pcrs_pkg::OP_PUSH && !full)
      begin
        stack_pointer_reg <= AW'(stack_pointer_reg + 5'h01); // [R9] [R14] [R20]
      end
      else if (op == pcrs_pkg::OP_POP && !empty)
      begin
        stack_pointer_reg <= AW'(stack_pointer_reg - 5'h01); // [R15] [R20]
      end
      else if (op == pcrs_pkg::OP_NONE && sw_wr && hit(reg_i.addr, pcrs_pkg::OFS_STACK_PTR))
      begin
        stack_pointer_reg <= reg_i.wdata[AW-1:0]; // [R13]
      end
    end
  end

  // Sticky flags; an event in the clearing cycle still sets the flag
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      ovf <= 1'b0;
      unf <= 1'b0;
    end
    else if (ce_i)
    begin
      if (op == pcrs_pkg::OP_PUSH && full)
      begin
        ovf <= 1'b1; // [R20]
      end
      else if (sw_wr && hit(reg_i.addr, pcrs_pkg::OFS_PWR_STAT0) &&
               !reg_i.wdata[pcrs_pkg::STAT_OVF_BIT])
      begin
        ovf <= 1'b0;
      end
      if (op == pcrs_pkg::OP_POP && empty)
      begin
        unf <= 1'b1; // [R20]
      end
      else if (sw_wr && hit(reg_i.addr, pcrs_pkg::OFS_PWR_STAT0) &&
               !reg_i.wdata[pcrs_pkg::STAT_UNF_BIT])
      begin
        unf <= 1'b0;
      end
    end
  end

  // Stack write: push of return address, or software top-of-stack byte write
  always_comb
  begin
    mem_we    = 1'b0;
    mem_waddr = stack_pointer_reg;
    mem_wdata = top_of_stack;
    if (op == pcrs_pkg::OP_PUSH)
    begin
      mem_we    = !full;
      mem_waddr = AW'(stack_pointer_reg + 5'h01); // [R14]
      mem_wdata = core_i.push_call ? next_pc_seq : pc; // [R14]
    end
    else if (op == pcrs_pkg::OP_NONE && sw_wr)
    begin
      mem_we = hit(reg_i.addr, pcrs_pkg::OFS_TOP_LOW) ||
               hit(reg_i.addr, pcrs_pkg::OFS_TOP_HIGH) ||
               hit(reg_i.addr, pcrs_pkg::OFS_TOP_UPPER); // [R13] [R18]
      if (hit(reg_i.addr, pcrs_pkg::OFS_TOP_LOW))
      begin
        mem_wdata[7:0] = reg_i.wdata;
      end
      if (hit(reg_i.addr, pcrs_pkg::OFS_TOP_HIGH))
      begin
        mem_wdata[15:8] = reg_i.wdata;
      end
      if (hit(reg_i.addr, pcrs_pkg::OFS_TOP_UPPER))
      begin
        mem_wdata[20:16] = reg_i.wdata[4:0];
      end
    end
  end

  pcrs_stack_mem #(
    .DEPTH (pcrs_pkg::DEPTH),
    .W     (W),
    .AW    (AW)
  ) pcrs_stack_mem_i (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (stack_pointer_reg),
    .rdata_o (top_of_stack) // [R18]
  );

  // Read data one cycle after the strobe; upper bits of narrow fields read zero
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (ce_i && sw_rd)
    begin
      case (reg_i.addr)
        pcrs_pkg::OFS_PC_LOW:    rdata_o <= pc[7:0]; // [R1]
        pcrs_pkg::OFS_PC_HLATCH: rdata_o <= pc_high_latch;
        pcrs_pkg::OFS_PC_ULATCH: rdata_o <= {3'h0, pc_upper_latch};
        pcrs_pkg::OFS_TOP_LOW:   rdata_o <= top_of_stack[7:0]; // [R13]
        pcrs_pkg::OFS_TOP_HIGH:  rdata_o <= top_of_stack[15:8];
        pcrs_pkg::OFS_TOP_UPPER: rdata_o <= {3'h0, top_of_stack[20:16]};
        pcrs_pkg::OFS_STACK_PTR: rdata_o <= {3'h0, stack_pointer_reg};
        pcrs_pkg::OFS_PWR_STAT0: rdata_o <= {ovf, unf, 6'h00}; // [R17]
        default:                 rdata_o <= 8'h00;
      endcase
    end
  end

  assign pc_o              = pc;
  assign stack_overflow_o  = ovf;
  assign stack_underflow_o = unf;

  // Assertions
  a_pc_word_align: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R6]
    pc[0] == 1'b0)
    else $error("pc lsb not zero");

  a_pc_step_two: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R7]
    ce_i && op == pcrs_pkg::OP_ADVANCE |=> pc == $past(pc) + 21'h2)
    else $error("pc did not advance by two");

  a_load_target: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R8]
    ce_i && op == pcrs_pkg::OP_LOAD
    |=> pc == $past(align(core_i.target)))
    else $error("load did not take target");

  a_push_jumps: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R8]
    ce_i && op == pcrs_pkg::OP_PUSH
    |=> pc == $past(align(core_i.target)))
    else $error("push did not jump to target");

  a_push_incr_sp: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R14]
    ce_i && op == pcrs_pkg::OP_PUSH && !full
    |=> stack_pointer_reg == $past(stack_pointer_reg) + 5'h1)
    else $error("push did not increment pointer");

  a_push_stores_ret: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R9]
    ce_i && core_i.push_call && !core_i.pop && !full
    |=> top_of_stack == $past(next_pc_seq))
    else $error("push stored wrong address");

  a_irq_stores_pc: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R14]
    ce_i && core_i.push_irq && !core_i.push_call && !core_i.pop && !full
    |=> top_of_stack == $past(pc))
    else $error("interrupt push stored wrong address");

  a_pop_loads_pc: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R15]
    ce_i && op == pcrs_pkg::OP_POP && !empty
    |=> pc == $past(align(top_of_stack)) &&
        stack_pointer_reg == $past(stack_pointer_reg) - 5'h1)
    else $error("pop wrong");

  a_ovf_no_wrap: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R20]
    ce_i && op == pcrs_pkg::OP_PUSH && full
    |=> ovf && stack_pointer_reg == $past(stack_pointer_reg))
    else $error("overflow not flagged");

  a_unf_no_wrap: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R20]
    ce_i && op == pcrs_pkg::OP_POP && empty
    |=> unf && pc == $past(pc) && stack_pointer_reg == 5'h0)
    else $error("underflow not flagged");

  a_latch_on_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R5]
    ce_i && sw_rd && reg_i.addr == pcrs_pkg::OFS_PC_LOW
    |=> pc_high_latch == $past(pc[15:8]) && pc_upper_latch == $past(pc[20:16]))
    else $error("latches not loaded on read");

  a_latch_on_write: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R4]
    ce_i && sw_wr && reg_i.addr == pcrs_pkg::OFS_PC_LOW && op == pcrs_pkg::OP_NONE
    |=> pc[20:8] == $past({pc_upper_latch, pc_high_latch}))
    else $error("latches not moved to pc");

  a_latch_keep_core: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R11]
    ce_i && op != pcrs_pkg::OP_NONE && !sw_wr && !sw_rd
    |=> pc_high_latch == $past(pc_high_latch) &&
        pc_upper_latch == $past(pc_upper_latch))
    else $error("core op changed a holding latch");

  a_read_pc_low: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R1]
    ce_i && sw_rd && reg_i.addr == pcrs_pkg::OFS_PC_LOW
    |=> rdata_o == $past(pc[7:0]))
    else $error("pc low byte read wrong");

  a_read_status: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R17]
    ce_i && sw_rd && reg_i.addr == pcrs_pkg::OFS_PWR_STAT0
    |=> rdata_o == $past({ovf, unf, 6'h00}))
    else $error("status read wrong");

  a_sp_sw_write: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R13]
    ce_i && op == pcrs_pkg::OP_NONE && sw_wr && reg_i.addr == pcrs_pkg::OFS_STACK_PTR
    |=> stack_pointer_reg == $past(reg_i.wdata[4:0]))
    else $error("pointer write not taken");

  a_top_sw_write: assert property (@(posedge clock_i) disable iff (!rstn_i) // [R18]
    ce_i && op == pcrs_pkg::OP_NONE && sw_wr && reg_i.addr == pcrs_pkg::OFS_TOP_LOW && !empty
    |=> top_of_stack[7:0] == $past(reg_i.wdata))
    else $error("top of stack write not taken");

  a_reset_sp_zero: assert property (@(posedge clock_i) // [R16]
    !rstn_i |=> stack_pointer_reg == 5'h0)
    else $error("reset did not clear pointer");

endmodule // pcrs_top
`default_nettype wire

/* verification/pcrs_core_model.sv */
// Core decode model: issues one-cycle control pulses to the counter block
`timescale 1ns/100ps
`default_nettype none
module pcrs_core_model (
  // Clock
  input  wire logic                       clock_i,
  // Requests towards the block
  output var  pcrs_pkg::pcrs_core_req_t   core_o
);
  initial core_o = '0;

  // Decode retires one instruction per cycle, so only one op bit is raised
  task automatic issue(input logic [4:0] ops, input logic [20:0] tgt);
    @(posedge clock_i);
    core_o <= {ops, tgt};
    @(posedge clock_i);
    core_o <= '0;
    #1;
  endtask
endmodule // pcrs_core_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the program counter and return stack
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [4:0] ADV = 5'h10;
  localparam logic [4:0] LD  = 5'h08;
  localparam logic [4:0] CALL = 5'h04;
  localparam logic [4:0] PIR = 5'h02;
  localparam logic [4:0] POP = 5'h01;

  logic                        clock_i = 1'b0;
  logic                        rstn_i  = 1'b0;
  pcrs_pkg::pcrs_reg_req_t     reg_i   = '0;
  pcrs_pkg::pcrs_core_req_t    core_w;
  logic [7:0]                  rdata_o;
  logic [pcrs_pkg::PC_W-1:0]   pc_o;
  logic                        ovf;
  logic                        unf;
  int                          n_mismatch = 0;
  int                          n_checks   = 0;
  logic [7:0]                  d;

  always #10 clock_i = ~clock_i;

  pcrs_core_model pcrs_core_model_i (.clock_i(clock_i), .core_o(core_w));

  pcrs_top pcrs_top_i (
    .clock_i           (clock_i),
    .ce_i              (1'b1),
    .rstn_i            (rstn_i),
    .core_i            (core_w),
    .reg_i             (reg_i),
    .rdata_o           (rdata_o),
    .pc_o              (pc_o),
    .stack_overflow_o  (ovf),
    .stack_underflow_o (unf)
  );

  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pc(input logic [20:0] exp);
    n_checks++;
    if (pc_o !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: pc %h expected %h", $time, pc_o, exp);
    end
  endtask

  task automatic chk_flags(input logic exp_ovf, input logic exp_unf);
    n_checks++;
    if (ovf !== exp_ovf || unf !== exp_unf)
    begin
      n_mismatch++;
      $display("Error at %0t: flags %b%b expected %b%b", $time, ovf, unf, exp_ovf, exp_unf);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    reg_i <= {a, v, 1'b1, 1'b0};
    @(posedge clock_i);
    reg_i <= '0;
  endtask

  // Read data appears in the cycle after the strobe and holds until the next read, so sample it there
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_i);
    reg_i <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clock_i);
    reg_i <= '0;
    #1;
    v = rdata_o;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk8(v, exp);
  endtask

  task automatic chk_top(input logic [20:0] e, input logic [7:0] sp);
    rd_chk(pcrs_pkg::OFS_TOP_LOW, e[7:0]);
    rd_chk(pcrs_pkg::OFS_TOP_HIGH, e[15:8]);
    rd_chk(pcrs_pkg::OFS_TOP_UPPER, {3'h0, e[20:16]});
    rd_chk(pcrs_pkg::OFS_STACK_PTR, sp);
  endtask

  task automatic t_advance();
    pcrs_core_model_i.issue(ADV, 21'h000000);
    pcrs_core_model_i.issue(ADV, 21'h000000);
    chk_pc(21'h000004);
  endtask

  task automatic t_latches();
    wr(pcrs_pkg::OFS_PC_HLATCH, 8'h12);
    wr(pcrs_pkg::OFS_PC_ULATCH, 8'h03);
    wr(pcrs_pkg::OFS_PC_LOW, 8'h57);
    #1;
    chk_pc(21'h031256);
    rd_chk(pcrs_pkg::OFS_PC_LOW, 8'h56);
    wr(pcrs_pkg::OFS_PC_HLATCH, 8'haa);
    rd_chk(pcrs_pkg::OFS_PC_LOW, 8'h56);
    rd_chk(pcrs_pkg::OFS_PC_HLATCH, 8'h12);
    rd_chk(pcrs_pkg::OFS_PC_ULATCH, 8'h03);
    rd_chk(4'hf, 8'h00);
  endtask

  // No interrupt acknowledge is issued while software touches the stack
  task automatic t_calls();
    pcrs_core_model_i.issue(LD, 21'h0abcd1);
    chk_pc(21'h0abcd0);
    rd_chk(pcrs_pkg::OFS_PC_HLATCH, 8'h12);
    pcrs_core_model_i.issue(CALL, 21'h001000);
    chk_pc(21'h001000);
    chk_top(21'h0abcd2, 8'h01);
    pcrs_core_model_i.issue(PIR, 21'h002000);
    chk_pc(21'h002000);
    chk_top(21'h001000, 8'h02);
    rd_chk(pcrs_pkg::OFS_PC_HLATCH, 8'h12);
  endtask

  task automatic t_pops();
    pcrs_core_model_i.issue(POP, 21'h000000);
    chk_pc(21'h001000);
    pcrs_core_model_i.issue(POP, 21'h000000);
    chk_pc(21'h0abcd2);
    rd_chk(pcrs_pkg::OFS_STACK_PTR, 8'h00);
    rd_chk(pcrs_pkg::OFS_PC_HLATCH, 8'h12);
    pcrs_core_model_i.issue(POP, 21'h000000);
    chk_pc(21'h0abcd2);
    rd(pcrs_pkg::OFS_PWR_STAT0, d);
    chk8(d & 8'hc0, 8'h40);
    chk_flags(1'b0, 1'b1);
    wr(pcrs_pkg::OFS_PWR_STAT0, 8'h00);
    rd(pcrs_pkg::OFS_PWR_STAT0, d);
    chk8(d & 8'hc0, 8'h00);
    chk_flags(1'b0, 1'b0);
  endtask

  task automatic t_overflow();
    wr(pcrs_pkg::OFS_STACK_PTR, 8'h1f);
    pcrs_core_model_i.issue(CALL, 21'h000400);
    chk_pc(21'h000400);
    rd_chk(pcrs_pkg::OFS_STACK_PTR, 8'h1f);
    rd(pcrs_pkg::OFS_PWR_STAT0, d);
    chk8(d & 8'hc0, 8'h80);
    chk_flags(1'b1, 1'b0);
  endtask

  // Software-built frame is returned through the normal pop path
  task automatic t_soft_stack();
    wr(pcrs_pkg::OFS_STACK_PTR, 8'h03);
    wr(pcrs_pkg::OFS_TOP_LOW, 8'h44);
    wr(pcrs_pkg::OFS_TOP_HIGH, 8'h33);
    wr(pcrs_pkg::OFS_TOP_UPPER, 8'h02);
    chk_top(21'h023344, 8'h03);
    pcrs_core_model_i.issue(POP, 21'h000000);
    chk_pc(21'h023344);
    rd_chk(pcrs_pkg::OFS_STACK_PTR, 8'h02);
  endtask

  initial
  begin
    repeat (3000) @(posedge clock_i);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    #1;
    chk_pc(21'h000000);
    rd_chk(pcrs_pkg::OFS_STACK_PTR, 8'h00);
    t_advance();
    t_latches();
    t_calls();
    t_pops();
    t_overflow();
    t_soft_stack();
    @(posedge clock_i);
    rstn_i <= 1'b0;
    @(posedge clock_i);
    rstn_i <= 1'b1;
    rd_chk(pcrs_pkg::OFS_STACK_PTR, 8'h00);
    chk_pc(21'h000000);
    chk_flags(1'b0, 1'b0);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
